/* File: hdl/qsfs_pkg.sv */
// Constants and types shared by the serial flash sequencer
package qsfs_pkg;

	// System clock
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS = 40;
	// Highest flash clock that stays reliable when hot
	localparam int unsigned SCK_MAX_HZ    = 26_670_000;

	// Addressing and command widths
	localparam int unsigned CMD_W    = 8;
	localparam int unsigned ADDR_W   = 24;
	localparam int unsigned ADDR_MSB = 23;

	// Last clock index of each phase, counted from zero
	localparam logic [5:0] CX_EXT         = 6'(7 + (ADDR_MSB + 1));
	localparam logic [5:0] CX_QUAD        = 6'(1 + (ADDR_MSB + 1) / 4);
	localparam logic [5:0] CMD_LAST_EXT   = 6'h07;
	localparam logic [5:0] CMD_LAST_QUAD  = 6'h01;
	localparam logic [5:0] BYTE_LAST_EXT  = 6'h07;
	localparam logic [5:0] BYTE_LAST_QUAD = 6'h01;

	// Register writes always carry a full word: 8+16 clocks single,
	// 2+4 clocks quad, so the last clock index is 23 or 5
	localparam int unsigned REG_BYTES = 2;

	// Chip select high time between transactions
	localparam int unsigned CS_HIGH_NS  = 50;
	localparam int unsigned CS_HIGH_CYC =
		(CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values of pins
	localparam logic [3:0] IO_OE_RST  = 4'h0;
	localparam logic [3:0] IO_OUT_RST = 4'h0;

	typedef enum logic [1:0] {
		KIND_REG_RD = 2'b00,
		KIND_REG_WR = 2'b01,
		KIND_MEM_RD = 2'b10,
		KIND_MEM_WR = 2'b11
	} qsfs_kind_type;

	typedef enum logic [2:0] {
		PH_IDLE  = 3'b000,
		PH_CA    = 3'b001,
		PH_DUMMY = 3'b010,
		PH_WDATA = 3'b011,
		PH_RDATA = 3'b100,
		PH_GAP   = 3'b101
	} qsfs_phase_type;

endpackage

/* File: hdl/qsfs_sequencer.sv */
// Serial flash command sequencer, single-line and quad protocols
`timescale 1ns/1ps

// Functional notes
// R1: All register reads issued in both protocols; reads with the lock-register read or write command refused.
// R2: Register read bytes arrive least significant first and land in that order.
// R3: All register writes issued in both protocols; writes with the lock-register read or write command refused.
// R4: Register write data leaves least significant byte first.
// R5: Register write runs to clock 23 single-line, clock 5 quad.
// R6: Memory commands carry a 24-bit address, sent most significant bit first.
// R7: Single-line command plus address phase ends at clock 7 + (23 + 1).
// R8: Quad command plus address phase ends at clock 1 + (23 + 1) / 4.
// R9: Fast reads in both protocols return bytes to the requester.
// R10: Page programs in both protocols take bytes from the requester.
// R11: Flash clock kept at or below about 26.67 MHz.
// R12: Chip select low for the whole transaction, high between transactions.
// R13: Outgoing data changes on falling edge, incoming sampled on rising edge.
module qsfs_sequencer #(
	parameter int unsigned  DIV         = 1,
	parameter int unsigned  LEN_W       = 9,
	parameter int unsigned  DUMMY_EXT   = 8,
	parameter int unsigned  DUMMY_QUAD  = 10,
	parameter logic [7:0]   LOCK_RD_CMD = 8'hE8,
	parameter logic [7:0]   LOCK_WR_CMD = 8'hE5
) (
	// Clock and reset
	input  wire logic               clk_in,
	input  wire logic               reset_n_in,
	// Request
	input  wire logic               req_valid_in,
	input  wire logic [1:0]         req_kind_in,
	input  wire logic               req_quad_in,
	input  wire logic [7:0]         req_cmd_in,
	input  wire logic [23:0]        req_addr_in,
	input  wire logic [LEN_W-1:0]   req_len_in,
	input  wire logic [15:0]        req_wdata_in,
	output logic                    req_ready_out,
	output logic                    req_err_out,
	output logic                    req_done_out,
	output logic [15:0]             reg_rdata_out,
	// Memory write data
	input  wire logic [7:0]         wr_data_in,
	input  wire logic               wr_valid_in,
	output logic                    wr_ack_out,
	// Memory read data
	output logic [7:0]              rd_data_out,
	output logic                    rd_valid_out,
	// Flash pins
	output logic                    flash_sck_out,
	output logic                    flash_cs_n_out,
	output logic [3:0]              flash_io_out,
	output logic [3:0]              flash_io_oe_out,
	input  wire logic [3:0]         flash_io_in
);

	// R11
	if (qsfs_pkg::CLK_HZ / (2 * DIV) > qsfs_pkg::SCK_MAX_HZ ||
		DIV < 1 || DIV > 255 || LEN_W < 2 || LEN_W > 16 ||
		DUMMY_EXT < 1 || DUMMY_QUAD < 1 ||
		DUMMY_EXT > 63 || DUMMY_QUAD > 63) begin : g_bad_param
		$error("qsfs_sequencer: unsupported parameter value");
	end
	localparam logic [7:0]  DIV_LAST = 8'(DIV - 1);
	localparam logic [5:0]  DUM_EXT_L = 6'(DUMMY_EXT - 1);
	localparam logic [5:0]  DUM_QUAD_L = 6'(DUMMY_QUAD - 1);
	localparam logic [5:0]  GAP_LAST = 6'(qsfs_pkg::CS_HIGH_CYC - 1);
	qsfs_pkg::qsfs_phase_type phase_r, phase_nxt;
	qsfs_pkg::qsfs_kind_type  kind_r, kind_nxt;
	logic              quad_r, quad_nxt;
	logic [5:0]        cnt_r, cnt_nxt;
	logic [LEN_W-1:0]  len_r, len_nxt;
	logic [LEN_W-1:0]  bidx_r, bidx_nxt;
	logic [31:0]       sh_r, sh_nxt;
	logic [15:0]       regw_r, regw_nxt;
	logic [7:0]        div_r;
	logic [7:0]        rx_r;
	logic [7:0]        rx_byte;
	logic              sck_r;
	logic              tick, active, last_bit, last_byte;
	logic              need_byte, stall, rise_ev, fall_ev;
	logic              accept, refuse, take;
	logic [5:0]        last_idx;
	// Pin drive: single-line keeps write-protect and hold lines high
	function automatic logic [7:0] pins(input logic quad, input logic tx,
		input logic [31:0] sh);
		if (quad)
			pins = {(tx ? 4'hF : 4'h0), sh[31:28]};
		else
			pins = {2'b11, 1'b0, tx, 2'b11, 1'b0, sh[31]};
	endfunction
	function automatic logic is_active(input qsfs_pkg::qsfs_phase_type ph);
		is_active = (ph == qsfs_pkg::PH_CA) || (ph == qsfs_pkg::PH_DUMMY) ||
			(ph == qsfs_pkg::PH_WDATA) || (ph == qsfs_pkg::PH_RDATA);
	endfunction
	// Clock divider runs only inside a transaction
	assign tick   = (div_r == DIV_LAST);
	assign active = is_active(phase_r);
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || !active || tick)
			div_r <= 8'h00;
		else
			div_r <= div_r + 8'h01;
	end
	// Last clock index of the current phase
	always_comb begin
		case (phase_r)
			qsfs_pkg::PH_CA: begin
				if (kind_r[1])
					last_idx = quad_r ? qsfs_pkg::CX_QUAD : qsfs_pkg::CX_EXT; // R7 R8
				else
					last_idx = quad_r ? qsfs_pkg::CMD_LAST_QUAD :
						qsfs_pkg::CMD_LAST_EXT;
			end
			qsfs_pkg::PH_DUMMY: last_idx = quad_r ? DUM_QUAD_L : DUM_EXT_L;
			default: last_idx = quad_r ? qsfs_pkg::BYTE_LAST_QUAD :
				qsfs_pkg::BYTE_LAST_EXT;
		endcase
	end
	assign last_bit  = (cnt_r == last_idx);
	assign last_byte = (bidx_r == len_r - LEN_W'(1));
	assign need_byte = last_bit &&
		((phase_r == qsfs_pkg::PH_CA && kind_r[0] == 1'b1) ||
		(phase_r == qsfs_pkg::PH_WDATA && !last_byte));
	// Clock parks high while the requester has no write byte ready
	assign stall   = need_byte && kind_r == qsfs_pkg::KIND_MEM_WR && !wr_valid_in;
	assign rise_ev = active && tick && !sck_r;
	assign fall_ev = active && tick && sck_r && !stall;
	assign rx_byte = quad_r ? {rx_r[3:0], flash_io_in} :
		{rx_r[6:0], flash_io_in[1]};
	// Sequencing
	always_comb begin
		phase_nxt = phase_r;
		kind_nxt  = kind_r;
		quad_nxt  = quad_r;
		cnt_nxt   = cnt_r;
		len_nxt   = len_r;
		bidx_nxt  = bidx_r;
		sh_nxt    = sh_r;
		regw_nxt  = regw_r;
		accept    = 1'b0;
		refuse    = 1'b0;
		take      = 1'b0;
		case (phase_r)
			qsfs_pkg::PH_IDLE: begin
				if (req_valid_in) begin
					if (!req_kind_in[1] && (req_cmd_in == LOCK_RD_CMD ||
						req_cmd_in == LOCK_WR_CMD)) begin
						refuse = 1'b1; // R1 R3
					end else begin
						accept    = 1'b1;
						phase_nxt = qsfs_pkg::PH_CA;
						kind_nxt  = qsfs_pkg::qsfs_kind_type'(req_kind_in);
						quad_nxt  = req_quad_in;
						cnt_nxt   = 6'h00;
						bidx_nxt  = '0;
						sh_nxt    = {req_cmd_in, req_addr_in}; // R6
						regw_nxt  = req_wdata_in;
						if (req_kind_in == qsfs_pkg::KIND_REG_WR)
							len_nxt = LEN_W'(qsfs_pkg::REG_BYTES); // R5
						else if (req_kind_in == qsfs_pkg::KIND_REG_RD)
							len_nxt = (req_len_in >= LEN_W'(2)) ?
								LEN_W'(2) : LEN_W'(1);
						else
							len_nxt = (req_len_in == '0) ? LEN_W'(1) : req_len_in;
					end
				end
			end
			qsfs_pkg::PH_GAP: begin
				if (cnt_r >= GAP_LAST)
					phase_nxt = qsfs_pkg::PH_IDLE;
				else
					cnt_nxt = cnt_r + 6'h01;
			end
			default: begin
				if (fall_ev) begin
					// R13
					sh_nxt = quad_r ? {sh_r[27:0], 4'h0} : {sh_r[30:0], 1'b0};
					if (!last_bit) begin
						cnt_nxt = cnt_r + 6'h01;
					end else begin
						cnt_nxt = 6'h00;
						case (phase_r)
							qsfs_pkg::PH_CA: begin
								if (kind_r[0])
									phase_nxt = qsfs_pkg::PH_WDATA;
								else if (kind_r[1])
									phase_nxt = qsfs_pkg::PH_DUMMY; // R9
								else
									phase_nxt = qsfs_pkg::PH_RDATA;
							end
							qsfs_pkg::PH_DUMMY: phase_nxt = qsfs_pkg::PH_RDATA;
							default: begin
								if (last_byte)
									phase_nxt = qsfs_pkg::PH_GAP; // R12
								else
									bidx_nxt = bidx_r + LEN_W'(1);
							end
						endcase
						if (need_byte) begin
							if (kind_r[1]) begin
								sh_nxt = {wr_data_in, 24'h00_0000}; // R10
								take   = 1'b1;
							end else begin
								sh_nxt   = {regw_r[7:0], 24'h00_0000}; // R4
								regw_nxt = {8'h00, regw_r[15:8]};
							end
						end
					end
				end
			end
		endcase
	end
	// State registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			phase_r <= qsfs_pkg::PH_IDLE;
			kind_r  <= qsfs_pkg::KIND_REG_RD;
			quad_r  <= 1'b0;
			cnt_r   <= 6'h00;
			len_r   <= '0;
			bidx_r  <= '0;
			sh_r    <= 32'h0000_0000;
			regw_r  <= 16'h0000;
		end else begin
			phase_r <= phase_nxt;
			kind_r  <= kind_nxt;
			quad_r  <= quad_nxt;
			cnt_r   <= cnt_nxt;
			len_r   <= len_nxt;
			bidx_r  <= bidx_nxt;
			sh_r    <= sh_nxt;
			regw_r  <= regw_nxt;
		end
	end
	// Flash clock, chip select and data pins
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sck_r           <= 1'b0;
			flash_cs_n_out  <= 1'b1;
			flash_io_out    <= qsfs_pkg::IO_OUT_RST;
			flash_io_oe_out <= qsfs_pkg::IO_OE_RST;
		end else begin
			if (rise_ev)
				sck_r <= 1'b1;
			else if (fall_ev)
				sck_r <= 1'b0;
			flash_cs_n_out <= !is_active(phase_nxt); // R12
			{flash_io_oe_out, flash_io_out} <= pins(quad_nxt,
				phase_nxt == qsfs_pkg::PH_CA ||
				phase_nxt == qsfs_pkg::PH_WDATA ||
				(phase_nxt == qsfs_pkg::PH_DUMMY && !quad_nxt), sh_nxt);
		end
	end
	assign flash_sck_out = sck_r;
	// Receive path samples on the rising flash clock
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rx_r          <= 8'h00;
			rd_data_out   <= 8'h00;
			rd_valid_out  <= 1'b0;
			reg_rdata_out <= 16'h0000;
		end else begin
			rd_valid_out <= 1'b0;
			if (accept && req_kind_in == qsfs_pkg::KIND_REG_RD)
				reg_rdata_out <= 16'h0000;
			if (rise_ev && phase_r == qsfs_pkg::PH_RDATA) begin // R13
				rx_r <= rx_byte;
				if (last_bit) begin
					if (kind_r[1]) begin
						rd_data_out  <= rx_byte; // R9
						rd_valid_out <= 1'b1;
					end else begin
						reg_rdata_out[bidx_r[0]*8 +: 8] <= rx_byte; // R2
					end
				end
			end
		end
	end
	// Requester handshakes
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			req_ready_out <= 1'b1;
			req_err_out   <= 1'b0;
			req_done_out  <= 1'b0;
			wr_ack_out    <= 1'b0;
		end else begin
			req_ready_out <= (phase_nxt == qsfs_pkg::PH_IDLE);
			req_err_out   <= refuse;
			req_done_out  <= (phase_r == qsfs_pkg::PH_GAP &&
				phase_nxt == qsfs_pkg::PH_IDLE);
			wr_ack_out    <= take;
		end
	end

endmodule

/* File: verification/qsfs_flash_model.sv */
// Behavioural serial flash that logs what it sees and returns a pattern
`timescale 1ns/1ps
module qsfs_flash_model (
	// Flash pins
	input  wire logic       sck_in,
	input  wire logic       cs_n_in,
	input  wire logic [3:0] io_in,
	output logic [3:0]      io_out,
	// Test setup
	input  wire logic       quad_in,
	input  wire logic [7:0] start_in
);
	int          cnt = 0;
	logic [63:0] cap = '0;
	logic [15:0] pat = '0;
	logic [3:0]  drv = '0;
	// Deselected lines show the inverse so stale data cannot pass
	assign io_out = cs_n_in ? ~drv : drv;
	always @(negedge cs_n_in) begin
		cnt = 0;
		cap = '0;
		pat = 16'h5AC3;
	end
	always @(posedge sck_in) begin
		cnt = cnt + 1;
		cap = quad_in ? {cap[59:0], io_in} : {cap[62:0], io_in[0]};
	end
	always @(negedge sck_in) begin
		if (cnt >= start_in) begin
			drv = quad_in ? pat[15:12] : {4{pat[15]}};
			pat = quad_in ? {pat[11:0], pat[15:12]} : {pat[14:0], pat[15]};
		end
	end
endmodule

/* File: verification/qsfs_sequencer_monitor.sv */
// Protocol checker bound to the serial flash sequencer
`timescale 1ns/1ps
module qsfs_monitor (
	// Clock, reset and request
	input wire logic       clk_in,
	input wire logic       reset_n_in,
	input wire logic       req_valid_in,
	input wire logic [1:0] req_kind_in,
	input wire logic [7:0] req_cmd_in,
	input wire logic       req_ready_out,
	input wire logic       req_err_out,
	input wire logic       req_done_out,
	// Streams and pins
	input wire logic       wr_valid_in,
	input wire logic       wr_ack_out,
	input wire logic       rd_valid_out,
	input wire logic       flash_sck_out,
	input wire logic       flash_cs_n_out,
	input wire logic [3:0] flash_io_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	logic lk, lk_m;
	assign lk = req_cmd_in == 8'hE8 || req_cmd_in == 8'hE5;
	assign lk_m = req_cmd_in == (req_kind_in[0] ? 8'hE5 : 8'hE8)
		&& !req_kind_in[1];
	sequence s_take; req_valid_in && req_ready_out; endsequence
	// Gap keeps the flash deselected long enough before the next command
	sequence s_rest; (flash_cs_n_out && !req_done_out)[*2]; endsequence
	property p_err;
		s_take ##0 lk_m |=> req_err_out && req_ready_out && flash_cs_n_out;
	endproperty
	a_err: assert property (p_err) else $error("lock not refused");
	property p_acc;
		s_take ##0 (req_kind_in[1] || !lk)
			|=> !req_ready_out && !flash_cs_n_out;
	endproperty
	a_acc: assert property (p_acc) else $error("no select");
	property p_cs; req_ready_out |-> flash_cs_n_out; endproperty
	a_cs: assert property (p_cs) else $error("select while idle");
	property p_sck; flash_cs_n_out |-> !flash_sck_out; endproperty
	a_sck: assert property (p_sck) else $error("clock not parked");
	property p_shift;
		$rose(flash_sck_out) |-> $stable(flash_io_out);
	endproperty
	a_shift: assert property (p_shift) else $error("data on rise");
	property p_rd;
		rd_valid_out |-> $rose(flash_sck_out) && !flash_cs_n_out;
	endproperty
	a_rd: assert property (p_rd) else $error("read byte late");
	property p_ack;
		wr_ack_out |-> $past(wr_valid_in) && !$past(flash_cs_n_out);
	endproperty
	a_ack: assert property (p_ack) else $error("ack unasked");
	property p_gap;
		$rose(flash_cs_n_out) |-> s_rest ##[1:2] (req_done_out && req_ready_out);
	endproperty
	a_gap: assert property (p_gap) else $error("done timing");
endmodule
bind qsfs_sequencer qsfs_monitor u_mon (
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.req_valid_in(req_valid_in),
	.req_kind_in(req_kind_in),
	.req_cmd_in(req_cmd_in),
	.req_ready_out(req_ready_out),
	.req_err_out(req_err_out),
	.req_done_out(req_done_out),
	.wr_valid_in(wr_valid_in),
	.wr_ack_out(wr_ack_out),
	.rd_valid_out(rd_valid_out),
	.flash_sck_out(flash_sck_out),
	.flash_cs_n_out(flash_cs_n_out),
	.flash_io_out(flash_io_out)
);

/* File: verification/test_quad_spi_flash_sequencer.sv */
// Self-checking bench for the serial flash sequencer
`timescale 1ns/1ps
module test_quad_spi_flash_sequencer;
	logic        clk_in = 0, reset_n_in = 0, req_valid_in = 0;
	logic        req_quad_in = 0, wr_valid_in = 0;
	logic [1:0]  req_kind_in = '0;
	logic [7:0]  req_cmd_in = '0, wr_data_in = '0, start = '0, rd_data_out;
	logic [8:0]  req_len_in = '0;
	logic [23:0] req_addr_in = 24'h9A_BCDE;
	logic [15:0] req_wdata_in = 16'hBBAA, reg_rdata_out;
	logic        req_ready_out, req_err_out, req_done_out, rd_valid_out;
	logic        wr_ack_out, flash_sck_out, flash_cs_n_out;
	logic [3:0]  flash_io_out, flash_io_oe_out, flash_io_in, mdl_io;
	logic [7:0]  wq[$], rq[$];
	int          bad_count = 0, checks_done = 0, stall = 0;
	qsfs_sequencer dut (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.req_valid_in(req_valid_in),
		.req_kind_in(req_kind_in),
		.req_quad_in(req_quad_in),
		.req_cmd_in(req_cmd_in),
		.req_addr_in(req_addr_in),
		.req_len_in(req_len_in),
		.req_wdata_in(req_wdata_in),
		.req_ready_out(req_ready_out),
		.req_err_out(req_err_out),
		.req_done_out(req_done_out),
		.reg_rdata_out(reg_rdata_out),
		.wr_data_in(wr_data_in),
		.wr_valid_in(wr_valid_in),
		.wr_ack_out(wr_ack_out),
		.rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out),
		.flash_sck_out(flash_sck_out),
		.flash_cs_n_out(flash_cs_n_out),
		.flash_io_out(flash_io_out),
		.flash_io_oe_out(flash_io_oe_out),
		.flash_io_in(flash_io_in));
	qsfs_flash_model u_flash (.sck_in(flash_sck_out),
		.cs_n_in(flash_cs_n_out), .io_in(flash_io_in), .io_out(mdl_io),
		.quad_in(req_quad_in), .start_in(start));
	assign flash_io_in = flash_io_oe_out & flash_io_out
		| ~flash_io_oe_out & mdl_io;
	initial forever #20 clk_in = ~clk_in;
	// Collect read bytes; hand out write bytes, held back while stalled
	always @(posedge clk_in) begin
		if (rd_valid_out === 1'b1)
			rq.push_back(rd_data_out);
		if (wr_ack_out === 1'b1)
			void'(wq.pop_front());
		if (stall > 0)
			stall <= stall - 1;
		wr_valid_in <= wq.size() > 0 && stall == 0;
		wr_data_in <= wq.size() > 0 ? wq[0] : 8'h00;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic go(input logic [1:0] k, input logic q,
		input logic [7:0] c, input logic [8:0] n, input logic [7:0] s);
		int i;
		start = s;
		@(posedge clk_in);
		req_kind_in <= k;
		req_quad_in <= q;
		req_cmd_in <= c;
		req_len_in <= n;
		req_valid_in <= 1'b1;
		@(posedge clk_in);
		for (i = 0; i < 9 && req_ready_out !== 1'b1; i++)
			@(posedge clk_in);
		req_valid_in <= 1'b0;
		for (i = 0; i < 3000 && req_done_out !== 1'b1
			&& req_err_out !== 1'b1; i++)
			@(posedge clk_in);
	endtask
	task automatic t_lock;
		for (int k = 0; k < 2; k++) begin
			go(k[1:0], 1'b0, k ? 8'hE5 : 8'hE8, 9'd0, 8'd0);
			chk({req_err_out, req_ready_out, flash_cs_n_out}, 3'b111);
		end
	endtask
	task automatic t_reg(input logic q);
		logic [7:0] c[4] = '{8'h05, 8'h70, 8'hB5, 8'h81};
		foreach (c[i]) begin
			go(2'b00, q, c[i], 9'd2, q ? 8'd2 : 8'd8);
			chk(reg_rdata_out, 16'hC35A);
			chk(u_flash.cnt, q ? 2 + 4 : 8 + 16);
			go(2'b01, q, c[i] ^ 8'h80, 9'd0, 8'd0);
			chk(u_flash.cap[23:0], {c[i] ^ 8'h80, 16'hAABB});
			chk(u_flash.cnt, q ? 5 + 1 : 23 + 1);
		end
		go(2'b00, q, 8'h05, 9'd1, q ? 8'd2 : 8'd8);
		chk(reg_rdata_out, 16'h005A);
		chk(u_flash.cnt, q ? 2 + 2 : 8 + 8);
	endtask
	task automatic t_mem(input logic q);
		int ca;
		ca = q ? 1 + 24 / 4 + 1 : 7 + 24 + 1;
		wq = {8'h3C, 8'hF0};
		stall = 100;
		go(2'b11, q, 8'h02, 9'd2, 8'd0);
		chk(u_flash.cap[47:0], {8'h02, 24'h9A_BCDE, 16'h3CF0});
		chk(u_flash.cnt, ca + (q ? 4 : 16));
		rq.delete();
		go(2'b10, q, 8'h0B, 9'd2, 8'(ca + (q ? 10 : 8)));
		chk({rq.size(), rq[0], rq[1]}, {32'd2, 16'h5AC3});
		chk(u_flash.cnt, ca + (q ? 14 : 24));
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_lock;
		for (int q = 0; q < 2; q++) begin
			t_reg(q[0]);
			t_mem(q[0]);
		end
		report_and_stop;
	end
endmodule
